// File: hdl/wsc_watchdog.v
// Purpose: Watchdog timer with sleep and wake control for a small microcontroller core
// Assumes: Clock 10 MHz; oscillator tick and clock pins come from other domains
// Notes: Register port with read data one cycle after the read strobe
// Function
// R1: Watchdog counts ticks of the 31 kHz low-frequency internal oscillator.
// R2: Every reset loads period control with select 0100 and enable clear.
// R3: Watchdog held cleared while the oscillator start-up timer runs.
// R4: Configuration enable set keeps the watchdog running, software bit ignored.
// R5: Configuration enable clear lets the software bit start and stop it.
// R6: Period select bits 4..1 choose 1:32 doubling to 1:65536; codes above reserved.
// R7: Software enable at bit 0, reset zero; bits 7..5 read zero.
// R8: Count cleared when disabled, on clear instruction, oscillator fail, or fast-clock wake.
// R9: Crystal-clock wake keeps watchdog cleared until 1024 oscillator periods pass.
// R10: Shared 8-bit prescaler selectable by assignment and rate bits extends timeout.
// R11: Sleep entry clears but runs watchdog, sets timeout, clears powerdown, holds pins.
// R12: Watchdog reset is internal and never drives the master clear pin.
// R13: Master clear in sleep resets; watchdog or interrupt wake resumes execution.
// R14: Powerdown set at power-up, cleared in sleep; timeout cleared by watchdog wake.
// R15: An interrupt wakes from sleep if its own enable is set, whatever global enable.
// R16: After interrupt wake, run prefetched instruction, then vector 0004h if enabled.
// R17: Watchdog count cleared on every wake from sleep.
// R18: Pending enabled interrupt before sleep makes sleep a no-operation, nothing changes.
// R19: Interrupt during sleep: complete sleep effects, then wake immediately.
// R20: Only sources needing no on-chip clock may wake the device.
// R21: Software should clear the watchdog just before sleeping.
// R22: Overflow awake resets and clears timeout; overflow asleep wakes and resumes.
`timescale 1ns/1ps
`default_nettype none
`include "wsc_map.vh"
module wsc_watchdog (
   // Clock and reset
   input wire clock,
   input wire nrst,
   input wire powerOnReset,
   // Register port
   input wire [3:0] regAddr,
   input wire [7:0] regWrData,
   input wire regWrite,
   input wire regRead,
   output reg [7:0] regRdData,
   // Configuration word and clocking
   input wire configWatchdogEnable,
   input wire crystalClock,
   input wire oscFail,
   // Asynchronous inputs
   input wire lowFreqInternalOsc,
   input wire oscTosc,
   input wire masterClearPinN,
   input wire [7:0] asyncWakeFlags,
   // Core instructions
   input wire watchdogClearInstr,
   input wire sleepInstr,
   input wire [7:0] irqEnables,
   input wire [7:0] irqFlags,
   input wire globalIrqEnable,
   // Core control outputs
   output reg deviceResetReq,
   output reg sleeping,
   output reg oscDriverOff,
   output reg holdPorts,
   output reg resumeStrobe,
   output reg vectorTaken,
   output reg [12:0] vectorAddr,
   output reg timeoutFlag,
   output reg powerdownFlag,
   output reg masterClearPinOe,
   output reg watchdogRunning
);
   // States of the sleep controller
   localparam ST_AWAKE = 2'b00;
   localparam ST_SLEEP = 2'b01;
   localparam ST_OST = 2'b10;
   localparam [10:0] OST_LAST = `WSC_OST_TOSC - 11'h001;
   localparam [7:0] RST_OPT = `WSC_OPTION_RST;
   localparam [7:0] RST_PER = `WSC_PERIOD_RST;
   reg [7:0] timerOption;
   reg [7:0] periodControl;
   reg [1:0] state;
   reg [1:0] next_state;
   reg [10:0] ostCount;
   reg [`WSC_CNT_W-1:0] wdtCount;
   reg [2:0] syncLf;
   reg [1:0] syncTosc;
   reg syncToscLast;
   reg [1:0] syncMclr;
   reg [7:0] syncWake1;
   reg [7:0] syncWake2;
   reg wdtTickSel;
   wire lfTick;
   wire toscTick;
   wire enabled;
   wire wdtClear;
   wire baseTick;
   wire psTick;
   wire wdtOverflow;
   wire [7:0] wakeFlags;
   wire irqPending;
   wire [3:0] periodSel;
   wire [3:0] periodSafe;
   wire [`WSC_CNT_W-1:0] periodMask;
   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   always @(posedge clock) begin
      if (!nrst) begin
         syncLf <= 3'b000;
         syncTosc <= 2'b00;
         syncToscLast <= 1'b0;
         syncMclr <= 2'b11;
         syncWake1 <= 8'h00;
         syncWake2 <= 8'h00;
      end else begin
         syncLf <= {syncLf[1:0], lowFreqInternalOsc};
         syncTosc <= {syncTosc[0], oscTosc};
         syncToscLast <= syncTosc[1];
         syncMclr <= {syncMclr[0], masterClearPinN};
         syncWake1 <= asyncWakeFlags;
         syncWake2 <= syncWake1;
      end
   end
   // Rising edges of the oscillator inputs
   assign lfTick = syncLf[1] & ~syncLf[2]; // [R1]
   assign toscTick = syncTosc[1] & ~syncToscLast;
   // Wake sources that run without on-chip clocks, gated by own enable
   assign wakeFlags = (syncWake2 | irqFlags) & irqEnables; // [R15] [R20]
   assign irqPending = |wakeFlags;
   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   always @(posedge clock) begin
      if (!nrst) begin
         timerOption <= RST_OPT;
         periodControl <= RST_PER; // [R2]
      end else if (regWrite) begin
         if (regAddr == `WSC_ADDR_OPTION) begin
            timerOption <= regWrData;
         end
         if (regAddr == `WSC_ADDR_PERIOD) begin
            periodControl <= {3'b000, regWrData[4:0]}; // [R7]
         end
      end
   end
   // Read data, one cycle after the strobe
   always @(posedge clock) begin
      if (!nrst) begin
         regRdData <= 8'h00;
      end else if (regRead) begin
         case (regAddr)
            `WSC_ADDR_OPTION: regRdData <= timerOption;
            `WSC_ADDR_PERIOD: regRdData <= {3'b000, periodControl[4:0]}; // [R7]
            `WSC_ADDR_STATUS: regRdData <= {3'b000, timeoutFlag, powerdownFlag, 3'b000};
            default: regRdData <= 8'h00;
         endcase
      end else begin
         regRdData <= 8'h00;
      end
   end
   // ------------------------------------------------------------
   // Watchdog counting
   // ------------------------------------------------------------
   assign enabled = configWatchdogEnable | periodControl[`WSC_SWEN_BIT]; // [R4] [R5]
   assign periodSel = periodControl[`WSC_PS_MSB:`WSC_PS_LSB];
   // Reserved codes behave as the longest period
   assign periodSafe = (periodSel > `WSC_PS_MAX) ? `WSC_PS_MAX : periodSel; // [R6]
   // Low 5+select bits of the count; all ones marks the last tick of a period
   assign periodMask = 16'hFFFF >> (`WSC_PS_MAX - periodSafe); // [R6]
   // Clear conditions
   assign wdtClear = !enabled || watchdogClearInstr || oscFail || (state == ST_OST) // [R3] [R8] [R9]
      || (state == ST_SLEEP && next_state != ST_SLEEP) // [R17]
      || (state == ST_AWAKE && next_state == ST_SLEEP); // [R11] [R19]
   // Main divider overflow at 2^(5+select) ticks
   always @(posedge clock) begin
      if (!nrst || wdtClear) begin
         wdtCount <= {`WSC_CNT_W{1'b0}};
         wdtTickSel <= 1'b0;
      end else begin
         wdtTickSel <= 1'b0;
         if (lfTick) begin
            wdtCount <= wdtCount + {{(`WSC_CNT_W-1){1'b0}}, 1'b1};
            wdtTickSel <= (wdtCount & periodMask) == periodMask; // [R6]
         end
      end
   end
   assign baseTick = wdtTickSel;
   // Shared prescaler, used by the watchdog when assigned to it
   wsc_prescaler uPrescaler (
      .clock(clock),
      .nrst(nrst),
      .clear(wdtClear | ~timerOption[`WSC_PSA_BIT]),
      .rate(timerOption[2:0]),
      .tickIn(baseTick),
      .tickOut(psTick)
   );
   assign wdtOverflow = timerOption[`WSC_PSA_BIT] ? psTick : baseTick; // [R10]
   // ------------------------------------------------------------
   // Sleep controller
   // ------------------------------------------------------------
   always @* begin
      next_state = state;
      case (state)
         ST_AWAKE: begin
            // A pending interrupt turns sleep into a no-operation
            if (sleepInstr && !irqPending) begin // [R18]
               next_state = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (!syncMclr[1]) begin
               next_state = ST_AWAKE; // [R13]
            end else if (irqPending || wdtOverflow) begin
               next_state = crystalClock ? ST_OST : ST_AWAKE; // [R9]
            end
         end
         ST_OST: begin
            // Leave on the last counted oscillator edge, not one early
            if (toscTick && ostCount == OST_LAST) begin // [R9]
               next_state = ST_AWAKE;
            end
         end
         default: next_state = ST_AWAKE;
      endcase
   end
   // State, start-up count and sleep outputs
   always @(posedge clock) begin
      if (!nrst) begin
         state <= ST_AWAKE;
         ostCount <= 11'h000;
         deviceResetReq <= 1'b0;
         resumeStrobe <= 1'b0;
         vectorTaken <= 1'b0;
         vectorAddr <= 13'h0000;
         sleeping <= 1'b0;
         oscDriverOff <= 1'b0;
         holdPorts <= 1'b0;
      end else begin
         state <= next_state;
         deviceResetReq <= 1'b0;
         resumeStrobe <= 1'b0;
         vectorTaken <= 1'b0;
         if (state == ST_OST) begin
            if (toscTick) begin
               ostCount <= ostCount + 11'h001;
            end
         end else begin
            ostCount <= 11'h000;
         end
         // Watchdog overflow while awake resets internally
         if (state == ST_AWAKE && wdtOverflow && !wdtClear) begin
            deviceResetReq <= 1'b1; // [R22] [R12]
         end
         if (state == ST_SLEEP && !syncMclr[1]) begin
            deviceResetReq <= 1'b1; // [R13]
         end else if (next_state == ST_AWAKE && state != ST_AWAKE) begin
            resumeStrobe <= 1'b1; // [R13] [R22]
            vectorTaken <= globalIrqEnable & irqPending; // [R16]
            vectorAddr <= (globalIrqEnable & irqPending) ? `WSC_IRQ_VECTOR : 13'h0000; // [R16]
         end
         sleeping <= (next_state == ST_SLEEP);
         oscDriverOff <= (next_state == ST_SLEEP); // [R11]
         holdPorts <= (next_state == ST_SLEEP); // [R11]
      end
   end
   // ------------------------------------------------------------
   // Status flags
   // ------------------------------------------------------------
   always @(posedge clock) begin
      if (!powerOnReset) begin
         timeoutFlag <= 1'b1;
         powerdownFlag <= 1'b1; // [R14]
      end else if (state == ST_AWAKE && wdtOverflow && !wdtClear) begin
         timeoutFlag <= 1'b0; // [R22]
      end else if (state == ST_SLEEP && wdtOverflow && !irqPending && syncMclr[1]) begin
         timeoutFlag <= 1'b0; // [R14]
      end else if (watchdogClearInstr) begin
         timeoutFlag <= 1'b1;
         powerdownFlag <= 1'b1;
      end else if (state == ST_AWAKE && next_state == ST_SLEEP) begin
         timeoutFlag <= 1'b1; // [R11] [R19]
         powerdownFlag <= 1'b0; // [R14]
      end
   end
   // Pin is never driven; running indicator
   always @(posedge clock) begin
      if (!nrst) begin
         masterClearPinOe <= 1'b0;
         watchdogRunning <= 1'b0;
      end else begin
         masterClearPinOe <= 1'b0; // [R12]
         watchdogRunning <= enabled && state != ST_OST; // [R3]
      end
   end
endmodule // wsc_watchdog
`default_nettype wire

// File: hdl/wsc_map.vh
// Purpose: Register offsets, field positions, reset values and counts of the watchdog block
// Assumes: Included by the watchdog design files
// Notes: Definitions only
`ifndef WSC_MAP_VH
`define WSC_MAP_VH
// Register offsets
`define WSC_ADDR_OPTION 4'h0
`define WSC_ADDR_PERIOD 4'h1
`define WSC_ADDR_STATUS 4'h2
// Reset values
`define WSC_OPTION_RST 8'hFF
`define WSC_PERIOD_RST 8'h08
// Field positions
`define WSC_PSA_BIT 3
`define WSC_SWEN_BIT 0
`define WSC_PS_LSB 1
`define WSC_PS_MSB 4
`define WSC_TO_BIT 4
`define WSC_PD_BIT 3
// Largest legal period select code
`define WSC_PS_MAX 4'hB
// Timing
`define WSC_LFOSC_KHZ 31
`define WSC_OST_TOSC 11'h400
// Width of the main watchdog counter
`define WSC_CNT_W 16
// Interrupt vector handed to the core
`define WSC_IRQ_VECTOR 13'h0004
`endif

// File: hdl/wsc_prescaler.v
// Purpose: Shared 8-bit prescaler that can extend the watchdog period
// Assumes: Tick input is one clock wide
// Notes: Rate 0 divides by 1, each step doubles, up to 1:128
`timescale 1ns/1ps
`default_nettype none
module wsc_prescaler (
   // Clock and reset
   input wire clock,
   input wire nrst,
   // Control
   input wire clear,
   input wire [2:0] rate,
   // Ticks
   input wire tickIn,
   output reg tickOut
);
   reg [7:0] count;
   wire [7:0] next_count;
   wire hit;
   assign next_count = count + 8'h01;
   // Division by two to the power of the rate
   assign hit = (next_count & ((8'h01 << rate) - 8'h01)) == 8'h00;
   // ------------------------------------------------------------
   // Divider
   // ------------------------------------------------------------
   always @(posedge clock) begin
      if (!nrst || clear) begin
         count <= 8'h00;
         tickOut <= 1'b0;
      end else begin
         tickOut <= 1'b0;
         if (tickIn) begin
            count <= next_count;
            tickOut <= hit;
         end
      end
   end
endmodule // wsc_prescaler
`default_nettype wire

// File: test/wsc_watchdog_sva.sv
// Purpose: Port assertions of the watchdog block
// Assumes: Bound to every wsc_watchdog instance
// Notes: Wake windows allow for input synchronisers
`timescale 1ns/1ps
`default_nettype none
module wsc_watchdog_sva (
   // Watched ports
   input wire clock, nrst, regRead, masterClearPinN, sleepInstr, crystalClock,
   input wire globalIrqEnable, sleeping, oscDriverOff, holdPorts, resumeStrobe,
   input wire vectorTaken, deviceResetReq, timeoutFlag, powerdownFlag, masterClearPinOe,
   input wire [7:0] regRdData, irqEnables, irqFlags,
   input wire [12:0] vectorAddr
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   // Steps of a sleep request
   sequence s_go; sleepInstr && !sleeping && (irqEnables & irqFlags) == 8'h00; endsequence
   sequence s_noop; sleepInstr && !sleeping && (irqEnables & irqFlags) != 8'h00; endsequence
   sequence s_slept; ##[1:2] sleeping && !powerdownFlag && timeoutFlag; endsequence
   property p_pin; masterClearPinOe == 1'b0; endproperty
   property p_rd; !regRead |=> regRdData == 8'h00; endproperty
   property p_go; s_go |-> s_slept; endproperty
   property p_noop; s_noop |=> !sleeping && $stable(powerdownFlag) && $stable(timeoutFlag);
   endproperty
   property p_hold; sleeping |-> oscDriverOff && holdPorts; endproperty
   property p_irq; sleeping && !crystalClock && (irqEnables & irqFlags) != 8'h00
      |-> ##[1:6] resumeStrobe; endproperty
   property p_vec; vectorTaken |-> resumeStrobe && globalIrqEnable && vectorAddr == 13'h0004;
   endproperty
   property p_wdt; deviceResetReq && !$past(sleeping) && !$past(sleeping, 2)
      |-> ##[0:2] !timeoutFlag; endproperty
   property p_master_clear_pin; sleeping && $fell(masterClearPinN) |-> ##[2:6] deviceResetReq; endproperty
   a_pin: assert property (p_pin) else $error("clear pin driven");
   a_rd: assert property (p_rd) else $error("read data outside slot");
   a_go: assert property (p_go) else $error("sleep entry wrong");
   a_noop: assert property (p_noop) else $error("sleep not a no-op");
   a_hold: assert property (p_hold) else $error("pins or driver not held");
   a_irq: assert property (p_irq) else $error("no interrupt wake");
   a_vec: assert property (p_vec) else $error("vector wrong");
   a_wdt: assert property (p_wdt) else $error("timeout flag not cleared");
   a_master_clear_pin: assert property (p_master_clear_pin) else $error("no reset from clear pin");
endmodule // wsc_watchdog_sva
bind wsc_watchdog wsc_watchdog_sva chk_u (.*);
`default_nettype wire

// File: test/wsc_core_model.sv
// Purpose: Core model issuing clear and sleep instructions
// Assumes: Requests are single-cycle pulses
// Notes: A clear always goes out ahead of a sleep
`timescale 1ns/1ps
`default_nettype none
module wsc_core_model (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Requests
   input wire logic goSleep,
   input wire logic goClear,
   // Instructions
   output var logic watchdogClearInstr,
   output var logic sleepInstr
);
   logic pend;
   // Clear first, sleep one cycle later
   always @(posedge clock) begin
      if (!nrst) begin
         watchdogClearInstr <= 1'b0;
         sleepInstr <= 1'b0;
         pend <= 1'b0;
      end else begin
         watchdogClearInstr <= goSleep | goClear;
         pend <= goSleep;
         sleepInstr <= pend;
      end
   end
endmodule // wsc_core_model
`default_nettype wire

// File: test/wsc_watchdog_test.sv
// Purpose: Self-checking bench of the watchdog block
// Assumes: Oscillator inputs sped up to shorten counts
// Notes: One low-frequency oscillator tick every 8 clocks, one start-up oscillator tick every 3
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin failures++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, e, s); end end
module wsc_watchdog_test;
   logic clock = 0, nrst = 0, powerOnReset = 0, regWrite = 0, regRead = 0, oscFail = 0;
   logic configWatchdogEnable = 0, crystalClock = 0, lowFreqInternalOsc = 0, oscTosc = 0;
   logic masterClearPinN = 1, globalIrqEnable = 0, goSleep = 0, goClear = 0;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWrData = 8'h00, asyncWakeFlags = 8'h00, irqEnables = 8'h00;
   logic [7:0] irqFlags = 8'h00, regRdData, q;
   logic [12:0] vectorAddr;
   logic deviceResetReq, sleeping, oscDriverOff, holdPorts, resumeStrobe, vectorTaken;
   logic timeoutFlag, powerdownFlag, masterClearPinOe, watchdogRunning;
   logic watchdogClearInstr, sleepInstr;
   int failures = 0, checks_done = 0, n;
   typedef struct {logic w; logic [3:0] a; logic [7:0] d, e;} wsc_row_t;
   typedef struct {logic c; logic [7:0] o, p; int e;} wsc_to_t;
   wsc_row_t rows [7] = '{'{0, 4'h0, 8'h00, 8'hFF}, '{0, 4'h1, 8'h00, 8'h08},
      '{0, 4'h2, 8'h00, 8'h18}, '{1, 4'h1, 8'hFF, 8'h1F}, '{1, 4'h0, 8'h5A, 8'h5A},
      '{1, 4'h2, 8'h00, 8'h18}, '{0, 4'h7, 8'h00, 8'h00}};
   wsc_to_t tos [3] = '{'{0, 8'h00, 8'h01, 256}, '{1, 8'h00, 8'h00, 256},
      '{0, 8'h09, 8'h01, 512}};
   wsc_watchdog dut_u (.*);
   wsc_core_model core_u (.*);
   // Clocks
   initial forever #50 clock = ~clock;
   initial forever #400 lowFreqInternalOsc = ~lowFreqInternalOsc;
   initial forever #150 oscTosc = ~oscTosc;
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1;
      @(posedge clock) regWrite <= 0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clock);
      regAddr <= a;
      regRead <= 1;
      @(posedge clock) regRead <= 0;
      #1 q = regRdData;
   endtask
   task automatic setup(input logic c, input logic [7:0] o, p);
      @(posedge clock) nrst <= 0;
      repeat (16) @(posedge clock);
      nrst <= 1;
      configWatchdogEnable <= c;
      wr(4'h0, o);
      wr(4'h1, p);
   endtask
   task automatic await(input logic s, input int lim);
      n = 0;
      while (n < lim && (s ? resumeStrobe : deviceResetReq) !== 1'b1) begin
         @(posedge clock);
         #1 n++;
      end
   endtask
   task automatic nap;
      @(posedge clock) goSleep <= 1;
      @(posedge clock) goSleep <= 0;
      repeat (4) @(posedge clock);
      #1;
   endtask
   task automatic give_verdict;
      $display("Checks %0d, failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Hang guard
   initial begin
      #2000000 failures++;
      give_verdict();
   end
   // Main sequence
   initial begin
      repeat (16) @(posedge clock);
      nrst <= 1;
      powerOnReset <= 1;
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         rd(rows[i].a);
         `CHK("register", rows[i].e, q)
      end
      foreach (tos[i]) begin
         setup(tos[i].c, tos[i].o, tos[i].p);
         await(0, 2000);
         `CHK("overflow", 1'b1, n > tos[i].e - 24 && n < tos[i].e + 24)
         repeat (2) @(posedge clock);
         #1 `CHK("timeout", 1'b0, timeoutFlag)
         `CHK("running", 1'b1, watchdogRunning)
      end
      setup(0, 8'h00, 8'h01);
      wr(4'h1, 8'h00);
      await(0, 600);
      `CHK("stopped", 600, n)
      `CHK("idle", 1'b0, watchdogRunning)
      wr(4'h1, 8'h01);
      oscFail <= 1;
      await(0, 600);
      `CHK("osc fail", 600, n)
      oscFail <= 0;
      repeat (4) begin
         @(posedge clock) goClear <= 1;
         @(posedge clock) goClear <= 0;
         await(0, 200);
         `CHK("clear instr", 200, n)
      end
      for (int k = 0; k < 3; k++) begin
         setup(1, 8'h00, 8'h17);
         globalIrqEnable <= k == 0;
         crystalClock <= k == 2;
         irqEnables <= 8'h01;
         nap();
         `CHK("powerdown", 1'b0, powerdownFlag)
         @(posedge clock) irqFlags <= 8'h02;
         repeat (30) @(posedge clock);
         #1 `CHK("asleep", 1'b1, sleeping)
         @(posedge clock) irqFlags <= 8'h01;
         await(1, 5000);
         `CHK("wake", 1'b1, k == 2 ? n > 3000 : n < 20)
         `CHK("vector", k == 0, vectorTaken)
         @(posedge clock) irqFlags <= 8'h00;
      end
      crystalClock <= 0;
      setup(1, 8'h00, 8'h17);
      irqFlags <= 8'h01;
      nap();
      `CHK("no-op", 1'b1, powerdownFlag)
      setup(1, 8'h00, 8'h00);
      irqFlags <= 8'h00;
      nap();
      await(1, 600);
      @(posedge clock);
      #1 `CHK("wake flag", 1'b0, timeoutFlag)
      setup(1, 8'h00, 8'h17);
      nap();
      @(posedge clock) masterClearPinN <= 0;
      await(0, 20);
      `CHK("clear pin", 1'b1, n < 20)
      masterClearPinN <= 1;
      give_verdict();
   end
endmodule // wsc_watchdog_test
`default_nettype wire
